// file: hfo_pkg.sv
/*
 * Package for the high-frequency oscillator control block.
 * Holds register addresses, field positions, reset values and the clock enable carrier.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package hfo_pkg;
	// ****************
	// Register map
	// ****************
	localparam logic [7:0] HFO_ADDR_CONTROL = 8'hb2;
	localparam logic [7:0] HFO_ADDR_TRIM = 8'hb3;
	localparam logic [7:0] HFO_ADDR_LEGACY_MULT = 8'hb9;
	// Control field positions
	localparam int HFO_BIT_ENABLE = 7;
	localparam int HFO_BIT_READY = 6;
	localparam int HFO_BIT_SUSPEND = 5;
	// Reset values
	localparam logic [6:0] HFO_TRIM_RESET = 7'h40;
	localparam logic [1:0] HFO_DIV_RESET = 2'h0;
	localparam logic [7:0] HFO_LEGACY_MULT_VALUE = 8'he0;
	// System clock source codes
	localparam logic [2:0] HFO_SRC_SCALED = 3'h0;
	localparam logic [2:0] HFO_SRC_HALF = 3'h2;
	localparam logic [2:0] HFO_SRC_FULL = 3'h3;
	// Divider count width: divide by 32 at most
	localparam int HFO_DIV_W = 5;
	// Cycles from enable to frequency ready
	localparam logic [3:0] HFO_SETTLE_CYCLES = 4'h8;
	// Outgoing clock enables
	typedef struct packed {
		logic core_en;
		logic periph_en;
	} hfo_clk_en_t;
	// Suspend sequencer states
	typedef enum logic [2:0] {
		HFO_RUN = 3'b001,
		HFO_SUSP = 3'b010,
		HFO_WAKE = 3'b100
	} hfo_state_t;
endpackage
`default_nettype wire

// file: hfo_ctrl.sv
/*
 * High-frequency oscillator control: control, trim and legacy multiplier registers,
 * divide chain producing a one-cycle core clock enable, suspend and wake on pin edge.
 * Assumes the oscillator itself is represented by sys_clk_i; the SFR bus is synchronous.
 */
`default_nettype none
module hfo_ctrl
	import hfo_pkg::*;
#(
	parameter logic [6:0] TRIM_RESET = HFO_TRIM_RESET
) (
	input wire logic sys_clk_i, // Free-running reference clock
	input wire logic rst_n_i, // Asynchronous system reset, active low
	input wire logic sfr_wr_i, // SFR write strobe
	input wire logic sfr_rd_i, // SFR read strobe
	input wire logic [7:0] sfr_addr_i, // SFR address
	input wire logic [7:0] sfr_wdata_i, // SFR write data
	input wire logic [2:0] system_clock_source_select_i, // Clock source code
	input wire logic wake_edge_pin_i, // Wake pin
	output logic [7:0] sfr_rdata_o, // SFR read data
	output logic [6:0] hf_osc_trim_o, // Trim to analog oscillator
	output logic hf_osc_enable_o, // Oscillator enable to analog
	output logic hf_osc_run_o, // Oscillator running, not suspended
	output logic core_clock_en_o, // Core clock enable pulse
	output logic periph_clock_en_o, // Peripheral clock enable pulse
	output logic hf_selected_o // Internal oscillator is clock source
);
	// ****************
	// State
	// ****************
	logic [6:0] trim_q, trim_d;
	logic enable_q, enable_d;
	logic suspend_q, suspend_d;
	logic [1:0] div_sel_q, div_sel_d;
	logic [3:0] settle_q, settle_d;
	logic ready_q, ready_d;
	logic wake_pin_q, wake_pin_d;
	logic [HFO_DIV_W-1:0] div_cnt_q, div_cnt_d;
	hfo_state_t state_q, state_d;
	hfo_clk_en_t clk_en_q, clk_en_d;
	logic [7:0] rdata_q, rdata_d;
	logic hf_sel_q, hf_sel_d;
	logic run_q, run_d;
	logic wr_ctrl, wr_trim, wake_edge, tick, hf_src;
	logic [HFO_DIV_W-1:0] div_max;

	// Write decode
	assign wr_ctrl = sfr_wr_i && (sfr_addr_i == HFO_ADDR_CONTROL);
	assign wr_trim = sfr_wr_i && (sfr_addr_i == HFO_ADDR_TRIM);
	// Wake edge from registered pin, both polarities
	assign wake_edge = wake_edge_pin_i ^ wake_pin_q;
	// Internal oscillator is the clock source
	assign hf_src = (system_clock_source_select_i == HFO_SRC_SCALED) ||
		(system_clock_source_select_i == HFO_SRC_HALF) ||
		(system_clock_source_select_i == HFO_SRC_FULL);

	// ****************
	// Divide chain
	// ****************
	// Terminal count per source select and post-divider
	always_comb begin
		case (system_clock_source_select_i)
			HFO_SRC_HALF: div_max = 5'h01;
			HFO_SRC_FULL: div_max = 5'h00;
			default: begin
				case (div_sel_q)
					2'h0: div_max = 5'h1f;
					2'h1: div_max = 5'h0f;
					2'h2: div_max = 5'h07;
					default: div_max = 5'h03;
				endcase
			end
		endcase
	end
	assign tick = (div_cnt_q >= div_max);

	// ****************
	// Register file
	// ****************
	// Control and trim fields; unused bits are never stored
	always_comb begin
		trim_d = trim_q;
		enable_d = enable_q;
		suspend_d = suspend_q;
		div_sel_d = div_sel_q;
		// Wake clears suspend; a control write in the same cycle wins
		if (state_q == HFO_SUSP && wake_edge) begin
			suspend_d = 1'b0;
		end
		if (wr_trim) begin
			trim_d = sfr_wdata_i[6:0];
		end
		if (wr_ctrl) begin
			enable_d = sfr_wdata_i[HFO_BIT_ENABLE];
			suspend_d = sfr_wdata_i[HFO_BIT_SUSPEND];
			div_sel_d = sfr_wdata_i[1:0];
		end
	end
	// Register file flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trim_q <= TRIM_RESET;
			enable_q <= 1'b1;
			suspend_q <= 1'b0;
			div_sel_q <= HFO_DIV_RESET;
		end else begin
			trim_q <= trim_d;
			enable_q <= enable_d;
			suspend_q <= suspend_d;
			div_sel_q <= div_sel_d;
		end
	end

	// ****************
	// Suspend sequencer
	// ****************
	// Run, suspend on the bit, wake on either pin edge, then back to run
	always_comb begin
		state_d = state_q;
		case (state_q)
			HFO_RUN: begin
				if (suspend_q) begin
					state_d = HFO_SUSP;
				end
			end
			HFO_SUSP: begin
				if (wake_edge) begin
					state_d = HFO_WAKE;
				end
			end
			HFO_WAKE: begin
				state_d = HFO_RUN;
			end
			default: begin
				state_d = HFO_RUN;
			end
		endcase
	end
	// Sequencer flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= HFO_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************
	// Wake detect
	// ****************
	// Pin copy runs on the always-on clock, also while suspended
	always_comb begin
		wake_pin_d = wake_edge_pin_i;
	end
	// Wake pin flop; a pin high at reset gives one edge, ignored while running
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_pin_q <= 1'b0;
		end else begin
			wake_pin_q <= wake_pin_d;
		end
	end

	// ****************
	// Frequency ready
	// ****************
	// Count settling cycles of enabled running; ready once counted out
	always_comb begin
		if (!enable_q || state_q != HFO_RUN) begin
			settle_d = '0;
			ready_d = 1'b0;
		end else if (settle_q != HFO_SETTLE_CYCLES) begin
			settle_d = settle_q + 4'h1;
			ready_d = 1'b0;
		end else begin
			settle_d = settle_q;
			ready_d = 1'b1;
		end
	end
	// Ready flops; out of reset the enabled oscillator counts as settled
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_q <= HFO_SETTLE_CYCLES;
			ready_q <= 1'b1;
		end else begin
			settle_q <= settle_d;
			ready_q <= ready_d;
		end
	end

	// ****************
	// Divide counter
	// ****************
	// Counter parks at zero outside running, so pulses restart on a boundary
	always_comb begin
		if (state_q != HFO_RUN || !enable_q) begin
			div_cnt_d = '0;
		end else if (tick) begin
			div_cnt_d = '0;
		end else begin
			div_cnt_d = div_cnt_q + 5'h01;
		end
	end
	// Divide counter flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_d;
		end
	end

	// ****************
	// Clock enables
	// ****************
	// Whole-cycle pulses only, so gating never leaves a partial clock
	always_comb begin
		clk_en_d.core_en = 1'b1;
		clk_en_d.periph_en = 1'b1;
		if (hf_src) begin
			clk_en_d.core_en = (state_q == HFO_RUN) && enable_q && tick && !suspend_q;
			clk_en_d.periph_en = (state_q == HFO_RUN) && enable_q && tick && !suspend_q;
		end
	end
	// Clock enable flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_en_q <= '0;
		end else begin
			clk_en_q <= clk_en_d;
		end
	end

	// ****************
	// Status outputs
	// ****************
	// Running and source flags, registered so the outputs come from flops
	always_comb begin
		run_d = enable_d && (state_d == HFO_RUN);
		hf_sel_d = hf_src;
	end
	// Status flops; the internal oscillator is the source out of reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_q <= 1'b1;
			hf_sel_q <= 1'b1;
		end else begin
			run_q <= run_d;
			hf_sel_q <= hf_sel_d;
		end
	end

	// ****************
	// Read data
	// ****************
	// Read mux; unused bits and unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				HFO_ADDR_CONTROL: rdata_d = {enable_q, ready_q, suspend_q, 3'h0, div_sel_q};
				HFO_ADDR_TRIM: rdata_d = {1'b0, trim_q};
				HFO_ADDR_LEGACY_MULT: rdata_d = HFO_LEGACY_MULT_VALUE;
				default: rdata_d = 8'h00;
			endcase
		end
	end
	// Read data flop; data stands for the one cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs straight from flops
	assign sfr_rdata_o = rdata_q;
	assign hf_osc_trim_o = trim_q;
	assign hf_osc_enable_o = enable_q;
	assign hf_osc_run_o = run_q;
	assign core_clock_en_o = clk_en_q.core_en;
	assign periph_clock_en_o = clk_en_q.periph_en;
	assign hf_selected_o = hf_sel_q;
endmodule
`default_nettype wire

// file: hfo_ctrl_checker.sv
/* Concurrent checks on the hfo_ctrl ports.
   Assumes one clock and an active-low asynchronous reset. */
`default_nettype none
module hfo_ctrl_checker
	import hfo_pkg::*;
(
	input wire logic sys_clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic sfr_wr_i, // Write
	input wire logic sfr_rd_i, // Read
	input wire logic [7:0] sfr_addr_i, // Address
	input wire logic [7:0] sfr_wdata_i, // Data in
	input wire logic [2:0] system_clock_source_select_i, // Source
	input wire logic wake_edge_pin_i, // Wake pin
	input wire logic [7:0] sfr_rdata_o, // Data out
	input wire logic hf_osc_enable_o, // Enable
	input wire logic hf_osc_run_o, // Running
	input wire logic core_clock_en_o, // Core enable
	input wire logic hf_selected_o // Internal source
);
	// ******
	// Checks
	// ******
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Enabled suspend write with the pin quiet, and a pin edge
	sequence s_susp_wr;
		sfr_wr_i && sfr_addr_i == HFO_ADDR_CONTROL && sfr_wdata_i[7] && sfr_wdata_i[5]
			&& !$changed(wake_edge_pin_i);
	endsequence
	sequence s_edge;
		$changed(wake_edge_pin_i);
	endsequence
	reset_src_a: assert property (
		$rose(rst_n_i) |-> hf_selected_o) else $error("source not internal");
	legacy_read_a: assert property (
		sfr_rd_i && sfr_addr_i == HFO_ADDR_LEGACY_MULT |=> sfr_rdata_o == 8'he0) else $error("legacy");
	ctrl_unused_a: assert property (
		sfr_rd_i && sfr_addr_i == HFO_ADDR_CONTROL |=> sfr_rdata_o[4:2] == 3'h0) else $error("unused");
	enable_write_a: assert property (
		sfr_wr_i && sfr_addr_i == HFO_ADDR_CONTROL |=>
		{hf_osc_enable_o, 7'h00} == ($past(sfr_wdata_i) & 8'h80)) else $error("enable");
	ready_off_a: assert property (
		!hf_osc_enable_o [*2] ##0 (sfr_rd_i && sfr_addr_i == HFO_ADDR_CONTROL) |=>
		!sfr_rdata_o[6]) else $error("ready while off");
	susp_entry_a: assert property (
		s_susp_wr ##1 !$changed(wake_edge_pin_i) |=> !hf_osc_run_o) else $error("no suspend");
	susp_stop_a: assert property (
		(system_clock_source_select_i == HFO_SRC_SCALED && !hf_osc_run_o && hf_osc_enable_o
		&& !$changed(wake_edge_pin_i)) [*3] |-> !core_clock_en_o) else $error("clock runs");
	wake_resume_a: assert property (
		!hf_osc_run_o && hf_osc_enable_o ##0 s_edge |-> ##[1:4] hf_osc_run_o) else $error("no wake");
endmodule
bind hfo_ctrl hfo_ctrl_checker i_chk (.*);
`default_nettype wire

// file: hfo_ctrl_test.sv
/* Self-checking bench for hfo_ctrl: registers, divider rates, suspend and wake.
   Assumes the synchronous SFR strobes of the design. */
`default_nettype none
`define CK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module hfo_ctrl_test
	import hfo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Harness
	// ********
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
	logic wake_edge_pin_i = 1'b0, hf_osc_enable_o, hf_osc_run_o, core_clock_en_o;
	logic periph_clock_en_o, hf_selected_o;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
	logic [2:0] system_clock_source_select_i = 3'h0;
	logic [6:0] hf_osc_trim_o;
	int fails = 0, n_compared = 0;
	hfo_ctrl i_dut (.*);
	// Clock and bus helpers
	always #2 sys_clk_i = ~sys_clk_i;
	task step; @(posedge sys_clk_i); #1; endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i) {sfr_wr_i, sfr_addr_i, sfr_wdata_i} <= {1'b1, a, d};
		@(posedge sys_clk_i) sfr_wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge sys_clk_i) {sfr_rd_i, sfr_addr_i} <= {1'b1, a};
		@(posedge sys_clk_i) sfr_rd_i <= 1'b0;
		#1 `CK("rdata", e, sfr_rdata_o & m)
	endtask
	// Cycles between two core enable pulses once settled
	task gap(input int e);
		int c;
		repeat (40) step;
		for (c = 0; core_clock_en_o !== 1'b1 && c < 40; c++) step;
		step;
		for (c = 1; core_clock_en_o !== 1'b1 && c < 40; c++) step;
		`CK("gap", e, c)
		`CK("periph", 1'b1, periph_clock_en_o)
	endtask
	// ********
	// Scenarios
	// ********
	task t_reset;
		rd(HFO_ADDR_CONTROL, 8'hff, 8'hc0);
		repeat (12) step;
		`CK("sel", 1'b1, hf_selected_o)
		rd(HFO_ADDR_CONTROL, 8'hff, 8'hc0);
		rd(HFO_ADDR_TRIM, 8'hff, {1'b0, HFO_TRIM_RESET});
		rd(HFO_ADDR_LEGACY_MULT, 8'hff, 8'he0);
		rd(8'h00, 8'hff, 8'h00);
		gap(32);
	endtask
	task t_div;
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk_i) system_clock_source_select_i <= (i < 4) ? HFO_SRC_SCALED :
				(i == 4 ? HFO_SRC_HALF : HFO_SRC_FULL);
			wr(HFO_ADDR_CONTROL, 8'h80 | 8'(i & 3));
			gap(i < 4 ? 32 >> i : 6 - i);
		end
		@(posedge sys_clk_i) system_clock_source_select_i <= 3'h1;
		repeat (2) step;
		`CK("ext", 1'b0, hf_selected_o)
		@(posedge sys_clk_i) system_clock_source_select_i <= HFO_SRC_SCALED;
		repeat (2) step;
		`CK("sel", 1'b1, hf_selected_o)
	endtask
	task t_regs;
		wr(HFO_ADDR_CONTROL, 8'h1f);
		rd(HFO_ADDR_CONTROL, 8'hff, 8'h03);
		`CK("en", 1'b0, hf_osc_enable_o)
		wr(HFO_ADDR_TRIM, 8'hff);
		rd(HFO_ADDR_TRIM, 8'hff, 8'h7f);
		`CK("trim", 7'h7f, hf_osc_trim_o)
		wr(HFO_ADDR_LEGACY_MULT, 8'h00);
		rd(HFO_ADDR_LEGACY_MULT, 8'hff, 8'he0);
		wr(HFO_ADDR_CONTROL, 8'h80);
		repeat (12) step;
		rd(HFO_ADDR_CONTROL, 8'hff, 8'hc0);
	endtask
	task t_susp;
		int c;
		@(posedge sys_clk_i) system_clock_source_select_i <= HFO_SRC_SCALED;
		wr(HFO_ADDR_CONTROL, 8'ha3);
		repeat (3) step;
		for (c = 0; c < 40 && core_clock_en_o !== 1'b1; c++) step;
		`CK("stop", 40, c)
		`CK("pstop", 1'b0, periph_clock_en_o)
		`CK("run", 1'b0, hf_osc_run_o)
		rd(HFO_ADDR_CONTROL, 8'hbf, 8'ha3);
		@(posedge sys_clk_i) wake_edge_pin_i <= ~wake_edge_pin_i;
		repeat (4) step;
		`CK("run", 1'b1, hf_osc_run_o)
		rd(HFO_ADDR_CONTROL, 8'hbf, 8'h83);
		gap(4);
	endtask
	// Reset again in mid-run after trim and divider were changed
	task t_rerst;
		@(posedge sys_clk_i) rst_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(HFO_ADDR_CONTROL, 8'hff, 8'hc0);
		rd(HFO_ADDR_TRIM, 8'hff, {1'b0, HFO_TRIM_RESET});
		gap(32);
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_reset;
		t_div;
		t_regs;
		t_susp;
		t_rerst;
		results;
	end
	// Tests need about 750 cycles; stop a hang well after that
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		fails++;
		results;
	end
endmodule
`default_nettype wire
